// file: verilog/etp_map.vh
// Constants for the external trigger pin block.
// What this block does
// RQ1: Polarity setting inverts pin both directions.
// RQ2: Defaults: trigger function, normal polarity.
// RQ3: Trigger output pulses on internal trigger.
// RQ4: Output pulse stays low at least 30us.
// RQ5: Input pulse starts only selected target.
// RQ6: External pulses must stay low 30us.
// RQ7: Pin starts sequence only if source external.
// RQ8: Manual source: key starts sequence, pin reports.
// RQ9: Measurement trigger needs host arm too.
// RQ10: Static output: true low, false high normally.
// RQ11: PWM output from frequency and duty settings.
`ifndef ETP_MAP_VH
`define ETP_MAP_VH
// ****************************************************************
// Clock and timing
// ****************************************************************
`define ETP_CLK_MHZ 250
`define ETP_PULSE_US 30
`define ETP_PULSE_CYC (`ETP_PULSE_US * `ETP_CLK_MHZ)
`define ETP_CNT_W 13
// ****************************************************************
// Function select codes
// ****************************************************************
`define ETP_FN_W 3
`define ETP_FN_TRIG 3'h0
`define ETP_FN_IN 3'h1
`define ETP_FN_OUT 3'h2
`define ETP_FN_PWM 3'h3
`define ETP_FN_DEFAULT `ETP_FN_TRIG
`define ETP_TDIR_OUT 1'h0
`define ETP_TDIR_IN 1'h1
// ****************************************************************
// Input targets and sequence source
// ****************************************************************
`define ETP_TGT_W 2
`define ETP_TGT_METER 2'h0
`define ETP_TGT_DLOG 2'h1
`define ETP_TGT_SEQ 2'h2
`define ETP_SRC_MANUAL 1'h0
`define ETP_SRC_EXT 1'h1
`define ETP_POL_NORMAL 1'h0
// ****************************************************************
// PWM setting widths
// ****************************************************************
`define ETP_PWM_W 16
`endif

// file: verilog/etp_pwm.v
// PWM generator for the trigger pin.
`timescale 1ns/100ps
`default_nettype none
`include "etp_map.vh"
module etp_pwm (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Settings
    input wire en,
    input wire [`ETP_PWM_W-1:0] period,
    input wire [`ETP_PWM_W-1:0] duty,
    // Waveform, logical true while high
    output reg pwm_q
);
    reg [`ETP_PWM_W-1:0] cnt_q; // Position in period
    // ****************************************************************
    // Period counter and compare
    // ****************************************************************
    // Period sets frequency, duty sets high count
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= {`ETP_PWM_W{1'b0}};
            pwm_q <= 1'b0;
        end else if (!en) begin
            cnt_q <= {`ETP_PWM_W{1'b0}};
            pwm_q <= 1'b0;
        end else begin
            // Wrap when period reached; zero period holds at zero
            if (cnt_q >= period)
                cnt_q <= {`ETP_PWM_W{1'b0}};
            else
                cnt_q <= cnt_q + {{(`ETP_PWM_W-1){1'b0}}, 1'b1};
            pwm_q <= (cnt_q < duty); // see RQ11
        end
    end
endmodule // etp_pwm
`default_nettype wire

// file: verilog/etp_top.v
// External trigger I/O pin: trigger in/out, static level and PWM.
`timescale 1ns/100ps
`default_nettype none
`include "etp_map.vh"
module etp_top (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Pin, three signals; oe_n low while driving
    input wire pin_i,
    output wire pin_o,
    output wire pin_oe_n,
    // Configuration
    input wire defaults_apply,
    input wire cfg_we,
    input wire [`ETP_FN_W-1:0] cfg_function,
    input wire cfg_trig_dir,
    input wire [`ETP_TGT_W-1:0] cfg_target,
    input wire cfg_invert,
    input wire sequence_trigger_source,
    input wire static_level,
    input wire [`ETP_PWM_W-1:0] pwm_period,
    input wire [`ETP_PWM_W-1:0] pwm_duty,
    // Instrument events
    input wire internal_trigger,
    input wire trigger_key,
    input wire meter_armed,
    // Started functions, one-cycle pulses
    output reg start_meter_q,
    output reg start_dlog_q,
    output reg start_seq_q,
    // Status
    output wire [`ETP_FN_W-1:0] function_q,
    output wire invert_q,
    output reg pulse_busy_q
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam ST_IDLE = 3'h1; // Waiting for edge
    localparam ST_LOW = 3'h2; // Pin low, counting
    localparam ST_WAIT = 3'h4; // Accepted, wait release
    // Idle spends one active cycle, so the input count stops one earlier
    localparam [31:0] IN_LAST = `ETP_PULSE_CYC - 2;
    localparam [31:0] OUT_LAST = `ETP_PULSE_CYC - 1; // Last output count
    reg [`ETP_FN_W-1:0] fn_q; // Selected function
    reg dir_q; // Trigger direction
    reg [`ETP_TGT_W-1:0] tgt_q; // Input target
    reg inv_q; // Polarity
    reg [2:0] sync_q; // Three-stage pin synchroniser
    reg in_act_q; // Filtered active level
    reg [2:0] st_q; // Input qualifier state
    reg [`ETP_CNT_W-1:0] icnt_q; // Input low time
    reg [`ETP_CNT_W-1:0] ocnt_q; // Output low time
    reg drive_q; // Logical output value
    wire pwm_w; // Generator waveform
    wire trig_out_mode; // Pulse output active
    wire trig_in_mode; // Pulse input active
    wire fire; // Cause of an output pulse
    wire in_valid; // Valid input pulse now
    assign trig_out_mode = (fn_q == `ETP_FN_TRIG) && (dir_q == `ETP_TDIR_OUT);
    assign trig_in_mode = (fn_q == `ETP_FN_TRIG) && (dir_q == `ETP_TDIR_IN);
    // Manual source lets key start sequence and report it
    assign fire = internal_trigger ||
        (trigger_key && sequence_trigger_source == `ETP_SRC_MANUAL); // see RQ3, RQ8
    // ****************************************************************
    // Configuration
    // ****************************************************************
    // Defaults win over a write in the same cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            fn_q <= `ETP_FN_DEFAULT;
            dir_q <= `ETP_TDIR_OUT;
            tgt_q <= `ETP_TGT_SEQ;
            inv_q <= `ETP_POL_NORMAL;
        end else if (defaults_apply) begin
            fn_q <= `ETP_FN_DEFAULT; // see RQ2
            dir_q <= `ETP_TDIR_OUT;
            tgt_q <= `ETP_TGT_SEQ;
            inv_q <= `ETP_POL_NORMAL; // see RQ2
        end else if (cfg_we) begin
            fn_q <= cfg_function;
            dir_q <= cfg_trig_dir;
            tgt_q <= cfg_target;
            inv_q <= cfg_invert;
        end
    end
    assign function_q = fn_q;
    assign invert_q = inv_q;
    // ****************************************************************
    // Input synchroniser
    // ****************************************************************
    // Level changes once stages two and three agree
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_q <= 3'h7;
            in_act_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], pin_i};
            if (sync_q[1] == sync_q[2])
                in_act_q <= sync_q[2] ^ ~inv_q; // see RQ1
        end
    end
    // ****************************************************************
    // Input pulse qualifier
    // ****************************************************************
    // Accept once the active level has held for the minimum width
    assign in_valid = (st_q == ST_LOW) && in_act_q &&
        (icnt_q == IN_LAST[`ETP_CNT_W-1:0]); // see RQ6, RQ5
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            icnt_q <= {`ETP_CNT_W{1'b0}};
        end else begin
            case (st_q)
                ST_IDLE: begin
                    icnt_q <= {`ETP_CNT_W{1'b0}};
                    if (trig_in_mode && in_act_q)
                        st_q <= ST_LOW;
                end
                ST_LOW: begin
                    if (!in_act_q || !trig_in_mode)
                        st_q <= ST_IDLE; // Too short, dropped
                    else if (in_valid)
                        st_q <= ST_WAIT; // One start per pulse
                    else
                        icnt_q <= icnt_q + {{(`ETP_CNT_W-1){1'b0}}, 1'b1};
                end
                ST_WAIT: begin
                    if (!in_act_q)
                        st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // ****************************************************************
    // Target dispatch
    // ****************************************************************
    // Input pulse starts only selected target; key starts sequence under manual source; gates from source and host arm
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_meter_q <= 1'b0;
            start_dlog_q <= 1'b0;
            start_seq_q <= 1'b0;
        end else begin
            start_meter_q <= in_valid && tgt_q == `ETP_TGT_METER
                && meter_armed; // see RQ5, RQ9
            start_dlog_q <= in_valid && tgt_q == `ETP_TGT_DLOG; // see RQ5
            start_seq_q <= (in_valid && tgt_q == `ETP_TGT_SEQ &&
                sequence_trigger_source == `ETP_SRC_EXT) || // see RQ7
                (trigger_key && sequence_trigger_source == `ETP_SRC_MANUAL); // see RQ8
        end
    end
    // ****************************************************************
    // Output pulse stretcher
    // ****************************************************************
    // Triggers during a pulse merge into it; no pulse is cut short
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_busy_q <= 1'b0;
            ocnt_q <= {`ETP_CNT_W{1'b0}};
        end else if (pulse_busy_q) begin
            if (ocnt_q == OUT_LAST[`ETP_CNT_W-1:0])
                pulse_busy_q <= 1'b0; // see RQ4
            else
                ocnt_q <= ocnt_q + {{(`ETP_CNT_W-1){1'b0}}, 1'b1};
        end else if (trig_out_mode && fire) begin
            pulse_busy_q <= 1'b1; // see RQ3
            ocnt_q <= {`ETP_CNT_W{1'b0}};
        end
    end
    // ****************************************************************
    // PWM generator
    // ****************************************************************
    etp_pwm u_pwm (
        .mclk(mclk),
        .rst(rst),
        .en(fn_q == `ETP_FN_PWM),
        .period(pwm_period),
        .duty(pwm_duty),
        .pwm_q(pwm_w)
    );
    // ****************************************************************
    // Pin driver
    // ****************************************************************
    // Logical true means low level before polarity
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            drive_q <= 1'b0;
        end else begin
            case (fn_q)
                `ETP_FN_TRIG: drive_q <= pulse_busy_q; // see RQ4
                `ETP_FN_OUT: drive_q <= static_level; // see RQ10
                `ETP_FN_PWM: drive_q <= pwm_w; // see RQ11
                default: drive_q <= 1'b0;
            endcase
        end
    end
    // Input modes release the pin
    assign pin_oe_n = (fn_q == `ETP_FN_IN) || trig_in_mode;
    assign pin_o = ~(drive_q ^ inv_q); // see RQ1, RQ10
endmodule // etp_top
`default_nettype wire

// file: verif/etp_sva.sv
// Checker for the external trigger pin block.
`timescale 1ns/100ps
`default_nettype none
`include "etp_map.vh"
module etp_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pin side
    input wire logic pin_o,
    input wire logic pin_oe_n,
    // Controls
    input wire logic defaults_apply,
    input wire logic sequence_trigger_source,
    input wire logic static_level,
    input wire logic internal_trigger,
    input wire logic trigger_key,
    input wire logic meter_armed,
    // Results
    input wire logic start_meter_q,
    input wire logic start_dlog_q,
    input wire logic start_seq_q,
    input wire logic [`ETP_FN_W-1:0] function_q,
    input wire logic invert_q,
    input wire logic pulse_busy_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [12:0] run_q; // Busy cycles so far
    always @(posedge mclk or posedge rst) begin
        if (rst) run_q <= 13'h0000;
        else run_q <= pulse_busy_q ? run_q + 13'h0001 : 13'h0000;
    end
    property p_fire;
        (internal_trigger && function_q == 3'h0 && !pin_oe_n && !pulse_busy_q) |=> pulse_busy_q;
    endproperty
    a_fire: assert property (p_fire) else $error("no pulse");
    property p_level; $rose(pulse_busy_q) |=> (pin_o == invert_q) [*8]; endproperty
    a_level: assert property (p_level) else $error("pulse level");
    property p_len; $fell(pulse_busy_q) |-> run_q >= 13'h1D4C; endproperty
    a_len: assert property (p_len) else $error("pulse short");
    property p_key; trigger_key && !sequence_trigger_source |=> start_seq_q; endproperty
    a_key: assert property (p_key) else $error("key start");
    property p_arm; start_meter_q |-> $past(meter_armed); endproperty
    a_arm: assert property (p_arm) else $error("unarmed meter");
    property p_ext;
        start_seq_q && !$past(trigger_key) |-> $past(sequence_trigger_source);
    endproperty
    a_ext: assert property (p_ext) else $error("seq source");
    property p_one;
        $onehot0({start_meter_q, start_dlog_q, start_seq_q && !$past(trigger_key)});
    endproperty
    a_one: assert property (p_one) else $error("two targets");
    property p_static;
        (function_q == 3'h2 && $stable(static_level) && $stable(invert_q)) [*4]
            |-> !pin_oe_n && pin_o == (!static_level ^ invert_q);
    endproperty
    a_static: assert property (p_static) else $error("static level");
    property p_dflt; defaults_apply |=> function_q == 3'h0 && !invert_q; endproperty
    a_dflt: assert property (p_dflt) else $error("defaults");
endmodule // etp_sva
`default_nettype wire

// file: verif/etp_far.sv
// Model of the external instrument on the trigger pin.
`timescale 1ns/100ps
`default_nettype none
module etp_far (
    // Clock
    input wire logic mclk,
    // Drive toward the pin
    output logic drive_en,
    output logic level
);
    // Released at start, pull-up gives high
    initial begin
        drive_en = 1'h0;
        level = 1'h1;
    end
    // Active level for low_cyc cycles, then idle; normal idle is released
    task automatic send(input int low_cyc, input logic act);
        @(negedge mclk);
        drive_en = 1'h1;
        level = act;
        repeat (low_cyc) @(negedge mclk);
        drive_en = act;
        level = !act;
    endtask
    // Idle level only: inverted idle is driven low, normal idle is released
    task automatic rest(input logic act);
        @(negedge mclk);
        drive_en = act;
        level = !act;
    endtask
endmodule // etp_far
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the external trigger pin block.
`timescale 1ns/100ps
`default_nettype none
`include "etp_map.vh"
module tb_top;
    logic mclk = 1'h0, rst = 1'h1, dflt = 1'h0, we = 1'h0, dir = 1'h0, inv = 1'h0;
    logic src = 1'h0, lvl = 1'h0, itrig = 1'h0, key = 1'h0, arm = 1'h0, clr = 1'h0;
    logic [2:0] fn = 3'h0, seen = 3'h0;
    logic [1:0] tgt = 2'h0;
    logic [15:0] per = 16'h0000, duty = 16'h0000;
    wire logic pin_o, pin_oe_n, f_en, f_lvl, s_m, s_d, s_s, inv_q, busy;
    wire logic [2:0] fn_q;
    wire logic pin = !pin_oe_n ? pin_o : (f_en ? f_lvl : 1'h1); // Pull-up when idle
    int miscompares = 0, samples_checked = 0, cyc = 0, i, n;
    logic [6:0] rows [5] = '{7'h0C, 7'h00, 7'h22, 7'h51, 7'h40}; // {tgt, src, arm, starts}
    initial forever #2 mclk = ~mclk;
    etp_top etp_top_inst (.mclk(mclk), .rst(rst), .pin_i(pin), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .defaults_apply(dflt), .cfg_we(we), .cfg_function(fn),
        .cfg_trig_dir(dir), .cfg_target(tgt), .cfg_invert(inv), .sequence_trigger_source(src),
        .static_level(lvl), .pwm_period(per), .pwm_duty(duty), .internal_trigger(itrig),
        .trigger_key(key), .meter_armed(arm), .start_meter_q(s_m), .start_dlog_q(s_d),
        .start_seq_q(s_s), .function_q(fn_q), .invert_q(inv_q), .pulse_busy_q(busy));
    etp_far etp_far_inst (.mclk(mclk), .drive_en(f_en), .level(f_lvl));
    // Collect start pulses and cut a hang short
    always @(posedge mclk) begin
        seen <= clr ? 3'h0 : (seen | {s_m, s_d, s_s});
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cfg(input logic [2:0] f, input logic d, input logic [1:0] t, input logic v);
        @(negedge mclk);
        {fn, dir, tgt, inv, we} = {f, d, t, v, 1'h1};
        @(negedge mclk);
        we = 1'h0;
    endtask
    // Cycles the pin spends at level a within a fixed window
    task count(input logic a, input int w);
        n = 0;
        repeat (w) begin
            @(negedge mclk);
            if (pin === a) n++;
        end
    endtask
    task wait_chk(input string nm, input logic [2:0] exp);
        repeat (20) @(negedge mclk);
        chk(nm, 16'(seen), 16'(exp));
    endtask
    // Forget earlier start pulses over one clock edge
    task clr_seen();
        clr = 1'h1;
        @(negedge mclk);
        clr = 1'h0;
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        rst = 1'h0;
        chk("idle", {10'h000, fn_q, inv_q, pin_oe_n, pin_o}, 16'h0001);
        for (i = 0; i < 2; i++) begin
            cfg(3'h0, 1'h0, 2'h2, i[0]);
            itrig = 1'h1;
            @(negedge mclk);
            itrig = 1'h0;
            count(i[0], 7600);
            chk("pulse", 16'(n), 16'h1D4C);
        end
        clr_seen();
        key = 1'h1;
        @(negedge mclk);
        key = 1'h0;
        count(1'h1, 7600);
        chk("key_pulse", 16'(n + 32'(seen)), 16'h1D4D);
        for (i = 0; i < 5; i++) begin
            cfg(3'h0, 1'h1, rows[i][6:5], 1'h0);
            {src, arm} = rows[i][4:3];
            clr_seen();
            etp_far_inst.send(7600, 1'h0);
            wait_chk("starts", rows[i][2:0]);
        end
        cfg(3'h0, 1'h1, 2'h1, 1'h0);
        clr_seen();
        etp_far_inst.send(7499, 1'h0);
        wait_chk("short", 3'h0);
        clr_seen();
        etp_far_inst.send(7500, 1'h0);
        wait_chk("exact", 3'h2);
        etp_far_inst.rest(1'h1);
        cfg(3'h0, 1'h1, 2'h1, 1'h1);
        clr_seen();
        etp_far_inst.send(7600, 1'h1);
        wait_chk("inv_in", 3'h2);
        etp_far_inst.rest(1'h0);
        lvl = 1'h1;
        cfg(3'h2, 1'h0, 2'h0, 1'h0);
        count(1'h0, 8);
        chk("static", 16'({pin_oe_n, pin_o}), 16'h0000);
        lvl = 1'h0;
        count(1'h0, 8);
        chk("static_false", 16'(pin_o), 16'h0001);
        lvl = 1'h1;
        cfg(3'h2, 1'h0, 2'h0, 1'h1);
        count(1'h0, 8);
        chk("static_inv", 16'(pin_o), 16'h0001);
        {per, duty} = {16'h0003, 16'h0001};
        cfg(3'h3, 1'h0, 2'h0, 1'h0);
        count(1'h0, 8);
        count(1'h0, 40);
        chk("pwm_low", 16'(n), 16'h000A);
        cfg(3'h3, 1'h0, 2'h0, 1'h1);
        dflt = 1'h1;
        @(negedge mclk);
        dflt = 1'h0;
        chk("defaults", 16'({fn_q, inv_q}), 16'h0000);
        tally_and_finish();
    end
endmodule // tb_top
bind etp_top etp_sva etp_sva_inst (.mclk(mclk), .rst(rst), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .defaults_apply(defaults_apply),
    .sequence_trigger_source(sequence_trigger_source), .static_level(static_level),
    .internal_trigger(internal_trigger), .trigger_key(trigger_key), .meter_armed(meter_armed),
    .start_meter_q(start_meter_q), .start_dlog_q(start_dlog_q), .start_seq_q(start_seq_q),
    .function_q(function_q), .invert_q(invert_q), .pulse_busy_q(pulse_busy_q));
`default_nettype wire
